// [link_rx.sv]
// Link receiver: brings reader clock, frame and data into the pclk domain.
// Assumes the link clock is far slower than pclk and data is stable at its rise.
`timescale 1ns/1ps
`default_nettype none

module link_rx (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic lnk_clk,
	input wire logic lnk_frame,
	input wire logic [7:0] lnk_data,
	output logic byte_stb,
	output logic [7:0] byte_dat,
	output logic frm_start,
	output logic frm_end
);

	logic [1:0] clk_s_r;
	logic [1:0] frm_s_r;
	logic [7:0] dat_s1_r;
	logic [7:0] dat_s2_r;
	logic clk_d_r;
	logic frm_d_r;

	// ****************************************
	// Two-stage synchronisers, then edge finders on stage two only
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_s_r <= 2'h0;
			frm_s_r <= 2'h0;
			dat_s1_r <= 8'h00;
			dat_s2_r <= 8'h00;
			clk_d_r <= 1'b0;
			frm_d_r <= 1'b0;
			byte_stb <= 1'b0;
			byte_dat <= 8'h00;
			frm_start <= 1'b0;
			frm_end <= 1'b0;
		end else begin
			clk_s_r <= {clk_s_r[0], lnk_clk};
			frm_s_r <= {frm_s_r[0], lnk_frame};
			dat_s1_r <= lnk_data;
			dat_s2_r <= dat_s1_r;
			clk_d_r <= clk_s_r[1];
			frm_d_r <= frm_s_r[1];
			// Byte taken at each link clock rise inside a frame
			byte_stb <= clk_s_r[1] & ~clk_d_r & frm_s_r[1];
			byte_dat <= dat_s2_r;
			frm_start <= frm_s_r[1] & ~frm_d_r;
			frm_end <= ~frm_s_r[1] & frm_d_r;
		end
	end

endmodule

`default_nettype wire

// [tb.sv]
// Bench for the write-ack response timer: APB host tasks plus reader frames.
// Assumes short timer parameters so an expiry takes a few microseconds.
`timescale 1ns/1ps
`default_nettype none
`include "wat_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t mismatch %h %h", $time, a, b); end end
`define WAITV(s, v) begin wn = 0; while ((s) !== (v) && wn < 5000) begin \
	@(posedge pclk); wn++; end if (wn >= 5000) `CHK(1'b0, 1'b1) end

module tb;
	import wat_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, lnk_clk, lnk_frame, resp_valid, irq, rdy, ind;
	logic [7:0] lnk_data;
	resp_t resp_out, last_rsp, ok, wx;
	int err_total = 0;
	int cmp_count = 0;
	int rsp_n = 0;
	int hold_n = 0;
	int wn, n0;

	write_ack_timer #(.RESP_CYC(200), .WTX_CYC(50)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk_clk(lnk_clk),
		.lnk_frame(lnk_frame), .lnk_data(lnk_data), .resp_valid(resp_valid),
		.resp_out(resp_out), .host_irq_out(irq), .host_port_ready_pin(rdy),
		.wait_extension_indicator(ind));
	wat_reader rdr (.lnk_clk(lnk_clk), .lnk_frame(lnk_frame), .lnk_data(lnk_data));

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (resp_valid === 1'b1) begin
			last_rsp <= resp_out;
			rsp_n <= rsp_n + 1;
		end
		// Cycles with the request raised and the ready pin still high
		if (irq !== 1'b1)
			hold_n <= 0;
		else if (rdy === 1'b1)
			hold_n <= hold_n + 1;
	end
	// ****
	// Tasks
	// ****
	task finish_test;
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) `CHK(1'b0, 1'b1)
		rd = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic service(input int add);
		int m = rsp_n;
		apb(1, `OFF_IFLAG, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1, `OFF_HRSP, 32'h1);
		repeat (4) @(posedge pclk);
		`CHK(rsp_n, m + add)
	endtask
	task automatic pkt(input logic [15:0] o, input logic [15:0] l, input logic [7:0] b);
		apb(0, `OFF_STATUS, 0);
		`CHK(rd[1:0], CMD_UPDATE)
		apb(0, `OFF_FILE_OFS, 0);
		`CHK(rd, {16'h0, o})
		apb(0, `OFF_BLK_LEN, 0);
		`CHK(rd, {16'h0, l})
		apb(0, `OFF_BUF_START, 0);
		`CHK(rd, `BUF_START_VAL)
		apb(0, `OFF_FILE_ID, 0);
		`CHK(rd, 32'h0000_E104)
		for (int i = 0; i < l; i++) begin
			apb(0, 12'(12'h400 + 4 * i), 0);
			`CHK(rd[7:0], 8'(b + i))
		end
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		presetn = 0;
		ok = '{RSP_STATUS, `SW1_OK, `SW2_OK};
		wx = '{RSP_WTX, 8'h05, 8'h00};
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, `OFF_CTRL, 0);
		`CHK(rd, 32'h0)
		apb(0, `OFF_XMS, 0);
		`CHK(rd[5:0], `XMS_RST)
		apb(0, `OFF_FWT_EXT, 0);
		`CHK(rd[5:0], `WTXM_RST)
		apb(0, `OFF_STATUS, 0);
		`CHK(rd[11:8], `FWI_MAX)
		apb(0, 12'hFFC, 0);
		`CHK(slv, 1'b1)
		rdr.send('{`CODE_SELECT, 8'hE1, 8'h04});
		`WAITV(irq, 1'b1)
		apb(0, `OFF_STATUS, 0);
		`CHK(rd[1:0], CMD_SELECT)
		service(1);
		`CHK(last_rsp, ok)
		apb(1, `OFF_CTRL, 32'h100);
		n0 = rsp_n;
		rdr.send('{`CODE_UPDATE, 8'h00, 8'h10, 8'hA1, 8'hA2, 8'hA3});
		`CHK(rsp_n, n0 + 1)
		`CHK(last_rsp, ok)
		`WAITV(irq, 1'b1)
		// Next packet arrives while the host still drains the first
		rdr.send('{`CODE_UPDATE, 8'h01, 8'h20, 8'hB1});
		`CHK(rsp_n, n0 + 2)
		pkt(16'h0010, 16'h3, 8'hA1);
		service(0);
		`WAITV(irq, 1'b1)
		pkt(16'h0120, 16'h1, 8'hB1);
		service(0);
		apb(1, `OFF_CTRL, 0);
		apb(1, `OFF_XMS, 32'h5);
		n0 = rsp_n;
		rdr.send('{`CODE_UPDATE, 8'h00, 8'h00, 8'hC1});
		`CHK(rsp_n, n0)
		`WAITV(rdy, 1'b0)
		`CHK(ind, 1'b0)
		`CHK(hold_n, 200)
		`WAITV(rdy, 1'b1)
		`CHK(wn, 51)
		`CHK(ind, 1'b1)
		repeat (2) @(posedge pclk);
		`CHK(last_rsp, wx)
		apb(0, `OFF_FWT_EXT, 0);
		`CHK(rd[5:0], 6'h05)
		rdr.send('{`CODE_READ, 8'h00, 8'h00});
		repeat (300) @(posedge pclk);
		`CHK(rsp_n, n0 + 1)
		`CHK(rdy, 1'b1)
		service(1);
		`CHK(last_rsp, ok)
		finish_test;
	end
	initial begin
		#300us;
		err_total++;
		finish_test;
	end
endmodule
`default_nettype wire

// [wat_chk.sv]
// Checker for the write-ack response timer, bound to its top ports.
// Assumes one pclk domain and presetn as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "wat_consts.svh"

module wat_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lnk_clk,
	input wire logic lnk_frame,
	input wire logic [7:0] lnk_data,
	input wire logic resp_valid,
	input wire wat_pkg::resp_t resp_out,
	input wire logic host_irq_out,
	input wire logic host_port_ready_pin,
	input wire logic wait_extension_indicator
);
	import wat_pkg::*;
	logic rd_acc;
	logic wtx;
	assign rd_acc = psel && penable && !pwrite;
	assign wtx = resp_valid && resp_out.kind == RSP_WTX;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// Properties
	// ****
	a_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_pins_paired: assert property (host_port_ready_pin == wait_extension_indicator)
		else $error("ready pin and indicator differ");
	a_ack_status_word: assert property (resp_valid && resp_out.kind == RSP_STATUS
		|-> resp_out.b0 == `SW1_OK && resp_out.b1 == `SW2_OK)
		else $error("bad status word");
	a_wtx_after_low: assert property (wtx |-> !$past(host_port_ready_pin))
		else $error("extension sent without expiry");
	a_wtx_release: assert property (wtx |=> host_port_ready_pin [*8])
		else $error("pins not back high after extension");
	a_wtx_delay: assert property ($fell(host_port_ready_pin) |-> !wtx [*8])
		else $error("extension sent too soon");
	a_wtx_bounded: assert property ($fell(host_port_ready_pin) |-> ##[1:1000] wtx)
		else $error("extension never sent");
	a_start_zero: assert property (rd_acc && paddr == `OFF_BUF_START
		|-> prdata == `BUF_START_VAL)
		else $error("buffer start not zero");
	a_fwi_max: assert property (rd_acc && paddr == `OFF_STATUS |-> prdata[11:8] == `FWI_MAX)
		else $error("wrong waiting time integer");
	c_status: cover property (resp_valid && resp_out.kind == RSP_STATUS);
	c_wtx: cover property (wtx);
	c_expiry: cover property ($fell(host_port_ready_pin));
endmodule

bind write_ack_timer wat_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .lnk_clk(lnk_clk), .lnk_frame(lnk_frame),
	.lnk_data(lnk_data), .resp_valid(resp_valid), .resp_out(resp_out),
	.host_irq_out(host_irq_out), .host_port_ready_pin(host_port_ready_pin),
	.wait_extension_indicator(wait_extension_indicator));
`default_nettype wire

// [wat_consts.svh]
// Constants of the write-ack response timer: offsets, bits, resets, timing.
// Assumes a 100 MHz register clock; included by bare name.
`ifndef WAT_CONSTS_SVH
`define WAT_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define PCLK_MHZ 100
`define RESP_TIMEOUT_US 55000
`define WTX_DELAY_US 3000
`define FWI_MAX 4'h8

// ****************************************
// Status words and link command codes
// ****************************************
`define SW1_OK 8'h90
`define SW2_OK 8'h00
`define CODE_SELECT 8'h01
`define CODE_READ 8'h02
`define CODE_UPDATE 8'h03
`define HDR_BYTES 16'h0003

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IFLAG 12'h008
`define OFF_HRSP 12'h00C
`define OFF_FILE_ID 12'h010
`define OFF_BUF_START 12'h014
`define OFF_FILE_OFS 12'h018
`define OFF_BLK_LEN 12'h01C
`define OFF_XMS 12'h020
`define OFF_FWT_EXT 12'h024
`define BUF_WIN_SEL 2'h1

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_AUTO_ACK_BIT 8
`define HRSP_DONE_BIT 0
`define IFLAG_GEN_BIT 0
`define XMS_RST 6'h01
`define WTXM_RST 6'h00
`define FID_RST 16'h0000
`define BUF_START_VAL 32'h0000_0000

`endif

// [wat_pkg.sv]
// Types shared by the write-ack response timer, its checker and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package wat_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_COPY = 3'h1,
		ST_PEND = 3'h3,
		ST_DELAY = 3'h2,
		ST_SEND = 3'h6
	} state_t;

	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_SELECT = 2'h1,
		CMD_READ = 2'h2,
		CMD_UPDATE = 2'h3
	} cmd_t;

	typedef enum logic {
		RSP_STATUS = 1'b0,
		RSP_WTX = 1'b1
	} rsp_kind_t;

	typedef struct packed {
		cmd_t cmd;
		logic [15:0] offset;
		logic [15:0] len;
		logic auto_acked;
	} hdr_t;

	typedef struct packed {
		rsp_kind_t kind;
		logic [7:0] b0;
		logic [7:0] b1;
	} resp_t;

endpackage

// [wat_reader.sv]
// Reader model: sends link frames byte by byte on a 125 ns link clock.
// Assumes the bench calls send with whole frames, one at a time.
`timescale 1ns/1ps
`default_nettype none

module wat_reader (
	output logic lnk_clk,
	output logic lnk_frame,
	output logic [7:0] lnk_data
);
	initial begin
		lnk_clk = 0;
		lnk_frame = 0;
		lnk_data = 8'h00;
	end
	// ****
	// Frame sender
	// ****
	task automatic send(input logic [7:0] q[$]);
		lnk_frame = 1;
		foreach (q[i]) begin
			lnk_data = q[i];
			#62.5 lnk_clk = 1;
			#62.5 lnk_clk = 0;
		end
		// Stale data would hide a late sample, so invert it
		lnk_data = ~lnk_data;
		#62.5 lnk_frame = 0;
		#100;
	endtask
endmodule
`default_nettype wire

// [write_ack_timer.sv]
// Write-ack response timer: nonblocking write handling and host response
// supervision with wait-time extension. APB slave on pclk; the reader link
// arrives on plain pins and is sampled by pclk through link_rx.
`timescale 1ns/1ps
`default_nettype none
`include "wat_consts.svh"

module write_ack_timer #(
	parameter int DEPTH = 256,
	parameter int RESP_CYC = `RESP_TIMEOUT_US * `PCLK_MHZ,
	parameter int WTX_CYC = `WTX_DELAY_US * `PCLK_MHZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lnk_clk,
	input wire logic lnk_frame,
	input wire logic [7:0] lnk_data,
	output logic resp_valid,
	output wat_pkg::resp_t resp_out,
	output logic host_irq_out,
	output logic host_port_ready_pin,
	output logic wait_extension_indicator
);
	import wat_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ****************************************
	// Declarations
	// ****************************************
	logic byte_stb;
	logic [7:0] byte_dat;
	logic frm_start;
	logic frm_end;

	logic [7:0] tmp_buf [DEPTH];
	logic [7:0] std_buf [DEPTH];

	state_t st_r, st_nxt;
	logic auto_r, auto_nxt;
	logic iflag_r, iflag_nxt;
	logic done_r, done_nxt;
	logic [5:0] xms_r, xms_nxt;
	logic [5:0] wtxm_r, wtxm_nxt;
	logic [15:0] fid_r, fid_nxt;
	hdr_t cur_r, cur_nxt;
	hdr_t tmp_r, tmp_nxt;
	logic tmp_full_r, tmp_full_nxt;
	logic accept_r, accept_nxt;
	logic [15:0] bcnt_r, bcnt_nxt;
	logic [15:0] cidx_r, cidx_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic wtx_sent_r, wtx_sent_nxt;
	logic rvalid_nxt;
	resp_t resp_nxt;
	logic ready_nxt;
	logic wind_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt;
	logic pslverr_nxt;

	logic wr_go;
	logic rd_setup;
	logic ack_now;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction

	function automatic logic in_buf(input logic [11:0] a);
		in_buf = (a[11:10] == `BUF_WIN_SEL) && (32'(a[9:2]) < DEPTH);
	endfunction

	function automatic cmd_t decode_cmd(input logic [7:0] code);
		case (code)
			`CODE_SELECT: decode_cmd = CMD_SELECT;
			`CODE_READ: decode_cmd = CMD_READ;
			`CODE_UPDATE: decode_cmd = CMD_UPDATE;
			default: decode_cmd = CMD_NONE;
		endcase
	endfunction

	link_rx u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.lnk_clk(lnk_clk),
		.lnk_frame(lnk_frame),
		.lnk_data(lnk_data),
		.byte_stb(byte_stb),
		.byte_dat(byte_dat),
		.frm_start(frm_start),
		.frm_end(frm_end)
	);

	// ****************************************
	// Buffers
	// ****************************************
	// Payload always lands in the temp buffer, so the host buffer never
	// changes under a host that is still draining it.
	always_ff @(posedge pclk) begin
		if (byte_stb && accept_r && bcnt_r >= `HDR_BYTES &&
				32'(bcnt_r - `HDR_BYTES) < DEPTH) begin
			tmp_buf[AW'(bcnt_r - `HDR_BYTES)] <= byte_dat;
		end
		if (st_r == ST_COPY && cidx_r < tmp_r.len && 32'(cidx_r) < DEPTH) begin
			std_buf[AW'(cidx_r)] <= tmp_buf[AW'(cidx_r)];
		end
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	assign wr_go = psel & penable & pready & pwrite;
	assign rd_setup = psel & ~penable;

	always_comb begin
		st_nxt = st_r;
		auto_nxt = auto_r;
		iflag_nxt = iflag_r;
		done_nxt = done_r;
		xms_nxt = xms_r;
		wtxm_nxt = wtxm_r;
		fid_nxt = fid_r;
		cur_nxt = cur_r;
		tmp_nxt = tmp_r;
		tmp_full_nxt = tmp_full_r;
		accept_nxt = accept_r;
		bcnt_nxt = bcnt_r;
		cidx_nxt = cidx_r;
		tmr_nxt = tmr_r;
		wtx_sent_nxt = wtx_sent_r;
		rvalid_nxt = 1'b0;
		resp_nxt = resp_out;
		ready_nxt = host_port_ready_pin;
		wind_nxt = wait_extension_indicator;
		ack_now = 1'b0;

		// Register writes
		if (wr_go) begin
			if (hit(paddr, `OFF_CTRL)) begin
				auto_nxt = pwdata[`CTRL_AUTO_ACK_BIT];
			end
			if (hit(paddr, `OFF_IFLAG) && pwdata[`IFLAG_GEN_BIT]) begin
				iflag_nxt = 1'b0;
			end
			if (hit(paddr, `OFF_HRSP) && pwdata[`HRSP_DONE_BIT]) begin
				done_nxt = 1'b1;
			end
			if (hit(paddr, `OFF_XMS)) begin
				xms_nxt = pwdata[5:0];
			end
		end

		// Frame reception
		if (frm_start) begin
			// A full temp buffer means the host fell behind: frame is dropped
			accept_nxt = ~tmp_full_r;
			bcnt_nxt = 16'h0000;
			tmp_nxt = tmp_full_r ? tmp_r : '0;
		end
		if (byte_stb && accept_r) begin
			bcnt_nxt = bcnt_r + 16'h0001;
			if (bcnt_r == 16'h0000) begin
				tmp_nxt.cmd = decode_cmd(byte_dat);
			end else if (bcnt_r == 16'h0001) begin
				tmp_nxt.offset[15:8] = byte_dat;
			end else if (bcnt_r == 16'h0002) begin
				tmp_nxt.offset[7:0] = byte_dat;
			end else begin
				tmp_nxt.len = tmp_r.len + 16'h0001;
			end
		end
		if (frm_end && accept_r) begin
			accept_nxt = 1'b0;
			if (tmp_r.cmd != CMD_NONE && bcnt_r >= `HDR_BYTES) begin
				if (auto_r && tmp_r.cmd == CMD_UPDATE) begin
					ack_now = 1'b1;
					tmp_nxt.auto_acked = 1'b1;
					tmp_full_nxt = 1'b1;
				end else if (st_r == ST_IDLE) begin
					tmp_full_nxt = 1'b1;
				end
				// Otherwise the frame meets an unserviced command and is not answered.
			end
		end
		if (ack_now) begin
			rvalid_nxt = 1'b1;
			resp_nxt = '{kind: RSP_STATUS, b0: `SW1_OK, b1: `SW2_OK};
		end

		unique case (st_r)
			ST_IDLE: begin
				if (tmp_full_r) begin
					cidx_nxt = 16'h0000;
					st_nxt = ST_COPY;
				end
			end
			ST_COPY: begin
				cidx_nxt = cidx_r + 16'h0001;
				if (cidx_r >= tmp_r.len) begin
					cur_nxt = tmp_r;
					if (tmp_r.cmd == CMD_SELECT) begin
						fid_nxt = tmp_r.offset;
					end
					tmp_full_nxt = ack_now;
					iflag_nxt = 1'b1;
					done_nxt = 1'b0;
					tmr_nxt = 32'h0000_0000;
					wtx_sent_nxt = 1'b0;
					st_nxt = ST_PEND;
				end
			end
			ST_PEND: begin
				if (done_r) begin
					// Done is kept while an auto ack holds the reply lane
					if (!cur_r.auto_acked && !ack_now) begin
						done_nxt = 1'b0;
						rvalid_nxt = 1'b1;
						resp_nxt = '{kind: RSP_STATUS, b0: `SW1_OK, b1: `SW2_OK};
						st_nxt = ST_IDLE;
					end else if (cur_r.auto_acked) begin
						done_nxt = 1'b0;
						st_nxt = ST_IDLE;
					end
				end else if (!wtx_sent_r) begin
					// After the extension the timer stops, so no second expiry occurs.
					tmr_nxt = tmr_r + 32'h0000_0001;
					if (tmr_r >= 32'(RESP_CYC - 1)) begin
						ready_nxt = 1'b0;
						wind_nxt = 1'b0;
						tmr_nxt = 32'h0000_0000;
						st_nxt = ST_DELAY;
					end
				end
			end
			ST_DELAY: begin
				tmr_nxt = tmr_r + 32'h0000_0001;
				if (tmr_r >= 32'(WTX_CYC - 1)) begin
					st_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				// An auto ack in this cycle owns the reply lane; retry next cycle
				if (!ack_now) begin
					wtxm_nxt = xms_r;
					rvalid_nxt = 1'b1;
					resp_nxt = '{kind: RSP_WTX, b0: {2'b00, xms_r}, b1: 8'h00};
					ready_nxt = 1'b1;
					wind_nxt = 1'b1;
					wtx_sent_nxt = 1'b1;
					st_nxt = ST_PEND;
				end
			end
		endcase

		// APB answer: registered in setup, shown in the access phase
		pready_nxt = rd_setup;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		if (rd_setup) begin
			if (hit(paddr, `OFF_CTRL)) begin
				prdata_nxt[`CTRL_AUTO_ACK_BIT] = auto_r;
			end else if (hit(paddr, `OFF_STATUS)) begin
				prdata_nxt = {19'h0, st_r != ST_IDLE, `FWI_MAX, 6'h00, cur_r.cmd};
			end else if (hit(paddr, `OFF_IFLAG)) begin
				prdata_nxt[`IFLAG_GEN_BIT] = iflag_r;
			end else if (hit(paddr, `OFF_HRSP)) begin
				prdata_nxt[`HRSP_DONE_BIT] = done_r;
			end else if (hit(paddr, `OFF_FILE_ID)) begin
				prdata_nxt = {16'h0000, fid_r};
			end else if (hit(paddr, `OFF_BUF_START)) begin
				prdata_nxt = `BUF_START_VAL;
			end else if (hit(paddr, `OFF_FILE_OFS)) begin
				prdata_nxt = {16'h0000, cur_r.offset};
			end else if (hit(paddr, `OFF_BLK_LEN)) begin
				prdata_nxt = {16'h0000, cur_r.len};
			end else if (hit(paddr, `OFF_XMS)) begin
				prdata_nxt = {26'h0, xms_r};
			end else if (hit(paddr, `OFF_FWT_EXT)) begin
				prdata_nxt = {26'h0, wtxm_r};
			end else if (in_buf(paddr)) begin
				prdata_nxt = {24'h0, std_buf[AW'(paddr[9:2])]};
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_IDLE;
			auto_r <= 1'b0;
			iflag_r <= 1'b0;
			done_r <= 1'b0;
			xms_r <= `XMS_RST;
			wtxm_r <= `WTXM_RST;
			fid_r <= `FID_RST;
			cur_r <= '0;
			tmp_r <= '0;
			tmp_full_r <= 1'b0;
			accept_r <= 1'b0;
			bcnt_r <= 16'h0000;
			cidx_r <= 16'h0000;
			tmr_r <= 32'h0000_0000;
			wtx_sent_r <= 1'b0;
			resp_valid <= 1'b0;
			resp_out <= '0;
			host_irq_out <= 1'b0;
			host_port_ready_pin <= 1'b1;
			wait_extension_indicator <= 1'b1;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			st_r <= st_nxt;
			auto_r <= auto_nxt;
			iflag_r <= iflag_nxt;
			done_r <= done_nxt;
			xms_r <= xms_nxt;
			wtxm_r <= wtxm_nxt;
			fid_r <= fid_nxt;
			cur_r <= cur_nxt;
			tmp_r <= tmp_nxt;
			tmp_full_r <= tmp_full_nxt;
			accept_r <= accept_nxt;
			bcnt_r <= bcnt_nxt;
			cidx_r <= cidx_nxt;
			tmr_r <= tmr_nxt;
			wtx_sent_r <= wtx_sent_nxt;
			resp_valid <= rvalid_nxt;
			resp_out <= resp_nxt;
			host_irq_out <= iflag_nxt;
			host_port_ready_pin <= ready_nxt;
			wait_extension_indicator <= wind_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

endmodule

`default_nettype wire
